// ==== adc_seq_pkg.sv ====
package adc_seq_pkg;

	// register byte offsets on the apb window
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTL0 = 8'h04;
	localparam logic [7:0] OFS_CTL1 = 8'h08;
	localparam logic [7:0] OFS_SAMPLE0 = 8'h0c;
	localparam logic [7:0] OFS_SAMPLE1 = 8'h10;
	localparam logic [7:0] OFS_HIGH = 8'h14;
	localparam logic [7:0] OFS_LOW = 8'h18;
	localparam logic [7:0] OFS_SEQ0 = 8'h1c;
	localparam logic [7:0] OFS_SEQ1 = 8'h20;
	localparam logic [7:0] OFS_SEQ2 = 8'h24;
	localparam logic [7:0] OFS_DATA = 8'h28;

	// status bit positions
	localparam int ST_DONE = 0;
	localparam int ST_WDOG = 1;
	localparam int ST_BUSY = 2;

	// control_reg_zero field positions
	localparam int C0_WDCH = 0;
	localparam int C0_DONE_IE = 5;
	localparam int C0_WDOG_IE = 6;
	localparam int C0_SCAN = 8;
	localparam int C0_WD_SINGLE = 9;
	localparam int C0_DISC = 11;
	localparam int C0_DISC_CNT = 13;
	localparam int C0_WDOG_EN = 23;

	// control_reg_one field positions
	localparam int C1_ON = 0;
	localparam int C1_CONT = 1;
	localparam int C1_DMA = 8;
	localparam int C1_LEFT = 11;
	localparam int C1_TRIG_SEL = 17;
	localparam int C1_TRIG_EN = 20;
	localparam int C1_SW_START = 22;
	localparam int C1_SIX_BIT = 25;

	// sequence layout: length field in the first sequence register
	localparam int SEQ_LEN_POS = 20;
	localparam int SLOT_W = 5;

	// writable bits of each register
	localparam logic [31:0] CTL0_MASK = 32'h0080eb7f;
	localparam logic [31:0] CTL1_MASK = 32'h023e0903;
	localparam logic [31:0] SAMPLE0_MASK = 32'h3fffffff;
	localparam logic [31:0] SAMPLE1_MASK = 32'h00ffffff;
	localparam logic [31:0] SEQ0_MASK = 32'h00ffffff;
	localparam logic [31:0] SEQ_MASK = 32'h3fffffff;

	// reset values
	localparam logic [31:0] CTL0_RESET = 32'h00000000;
	localparam logic [31:0] CTL1_RESET = 32'h00000000;
	localparam logic [11:0] HIGH_RESET = 12'hfff;
	localparam logic [11:0] LOW_RESET = 12'h000;

	// software trigger code of the trigger select field
	localparam logic [2:0] TRIG_SOFTWARE = 3'h7;

	// conversion time in tenths of a converter clock, rounded up to cycles
	localparam int CONV_TENTHS = 125;
	localparam int CONV_CYCLES = (CONV_TENTHS + 9) / 10;
	// shortest sample window; each code step doubles it
	localparam int SAMPLE_BASE_CYCLES = 2;
	localparam int CNT_W = 9;

	// sequencer states
	typedef enum logic {SEQ_IDLE, SEQ_CONVERT} seq_state_t;

	// whole sample-plus-convert time for one sample time code
	function automatic logic [CNT_W-1:0] conv_total(input logic [2:0] code);
		conv_total = CNT_W'((SAMPLE_BASE_CYCLES << code) + CONV_CYCLES);
	endfunction

	// place a raw result into the 16-bit data register
	function automatic logic [15:0] align_result(input logic [11:0] raw, input logic left,
		input logic six);
		if (six)
			align_result = left ? {8'h00, raw[5:0], 2'h0} : {10'h000, raw[5:0]};
		else
			align_result = left ? {raw, 4'h0} : {4'h0, raw};
	endfunction

endpackage

// ==== adc_conv_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

// times one sample window plus the fixed conversion tail
module adc_conv_timer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic enable,
	input wire logic start,
	input wire logic [2:0] sample_code,
	// status
	output logic sampling,
	output logic busy,
	output logic done
);

	logic [adc_seq_pkg::CNT_W-1:0] count_q; // cycles left in this conversion
	logic [adc_seq_pkg::CNT_W-1:0] tail; // cycles that belong to the conversion tail

	assign tail = adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// down counter; a cleared enable drops any conversion in flight
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_q <= '0;
		else if (!enable)
			count_q <= '0;
		else if (start && count_q == '0)
			count_q <= adc_seq_pkg::conv_total(sample_code);
		else if (count_q != '0)
			count_q <= count_q - 1'b1;
	end

	// finish pulse in the cycle after the last count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done <= 1'b0;
		else
			done <= enable && count_q == 1;
	end

	// busy covers sampling and conversion
	assign busy = count_q != '0;
	// sampling while more than the tail remains
	assign sampling = count_q > tail;

endmodule

`default_nettype wire

// ==== adc_routine_sequencer.sv ====
// Function
// - result to data register, done flag set
// - done interrupt only when enabled
// - writing zero clears done flag
// - continuous repeats first slot channel
// - start by software bit or trigger
// - scan converts all slots in order
// - scan sets done after whole sequence
// - scan plus continuous restarts sequence
// - discontinuous converts next count-field-plus-one slots
// - discontinuous done once per pass
// - watchdog flags results outside thresholds
// - watchdog interrupt only when enabled
// - thresholds compare raw unaligned result
// - watchdog watches one or all channels
// - twelve-bit right or left alignment
// - six-bit right or left alignment
// - per-channel three-bit sample time
// - sample time plus conversion tail
// - length field in first sequence register
// - converter off holds sequencer and timer idle; flags and data keep their values
// - dma request after each channel
`timescale 1ns/100ps
`default_nettype none

module adc_routine_sequencer (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// hardware trigger pins, rising edge active
	input wire logic [6:0] hw_trigger,
	// analog sampling core
	output logic [4:0] sample_channel,
	output logic sample_active,
	output logic convert_active,
	input wire logic [11:0] conv_result,
	// requests
	output logic dma_request,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [31:0] ctl0_q; // control_reg_zero
	logic [31:0] ctl1_q; // control_reg_one
	logic [31:0] sample0_q; // sample_time_regs, channels 0..9
	logic [31:0] sample1_q; // sample_time_regs, channels 10..17
	logic [11:0] high_q; // high_threshold_reg
	logic [11:0] low_q; // low_threshold_reg
	logic [31:0] seq0_q; // sequence_regs, length and slots 12..15
	logic [31:0] seq1_q; // sequence_regs, slots 6..11
	logic [31:0] seq2_q; // sequence_regs, slots 0..5
	logic [15:0] data_q; // routine data register
	logic done_flag_q; // conversion done flag
	logic wd_flag_q; // watchdog_event_flag
	logic [31:0] prdata_q; // read data captured in setup
	logic dma_q; // dma request pulse

	adc_seq_pkg::seq_state_t state_q; // sequencer state
	logic [3:0] pos_q; // current sequence slot
	logic [2:0] group_q; // conversions done in this discontinuous burst
	logic [4:0] chan_q; // channel under conversion

	logic [6:0] trig_s1_all_q; // first stage of every trigger pin
	logic [6:0] trig_s2_q; // second stage
	logic [6:0] trig_s3_q; // edge history
	logic [6:0] trig_edge; // rising edges after synchronising

	logic wr_en; // apb write strobe
	logic rd_setup; // apb read setup cycle
	logic mapped; // address hits a register
	logic on; // converter_on
	logic scan; // scan_enable
	logic disc; // discontinuous_enable
	logic cont; // continuous_enable
	logic trigger; // a routine trigger this cycle
	logic conv_done; // channel conversion finished
	logic timer_busy; // conversion timer running
	logic launch; // start the next channel
	logic [3:0] launch_pos; // slot of the next channel
	logic [3:0] last_pos; // final slot of the sequence
	logic last_slot; // finished channel closes the sequence
	logic pass_done; // done flag event
	logic [4:0] launch_chan; // channel of the next slot
	logic [2:0] launch_code; // sample time code of that channel
	logic watched; // finished channel is monitored
	logic outside; // result outside the thresholds
	logic [11:0] raw; // raw result before alignment

	////////////////////////////////////////////////////////////////////////
	// helpers

	// slot k lives in the sequence registers, slot 0 in the last one
	function automatic logic [4:0] slot_chan(input logic [3:0] k, input logic [31:0] s0,
		input logic [31:0] s1, input logic [31:0] s2);
		logic [4:0] c;
		c = '0;
		if (k < 4'd6)
			c = s2[5*k +: 5];
		else if (k < 4'd12)
			c = s1[5*(k-4'd6) +: 5];
		else
			c = s0[5*(k-4'd12) +: 5];
		return c;
	endfunction

	// three-bit sample time code of a channel
	function automatic logic [2:0] sample_code(input logic [4:0] ch, input logic [31:0] t0,
		input logic [31:0] t1);
		logic [2:0] c;
		c = '0;
		if (ch < 5'd10)
			c = t0[3*ch +: 3];
		else if (ch < 5'd18)
			c = t1[3*(ch-5'd10) +: 3];
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, unmapped addresses answer with an error

	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;

	// address decode; the map is every aligned word up to the data register
	always_comb
	begin
		if (paddr <= adc_seq_pkg::OFS_DATA && paddr[1:0] == 2'h0)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	assign pslverr = psel && penable && !mapped;

	// read data is captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (rd_setup)
		begin
			if (paddr == adc_seq_pkg::OFS_STATUS)
				prdata_q <= {29'h0, state_q == adc_seq_pkg::SEQ_CONVERT, wd_flag_q, done_flag_q};
			else if (paddr == adc_seq_pkg::OFS_CTL0)
				prdata_q <= ctl0_q;
			else if (paddr == adc_seq_pkg::OFS_CTL1)
				prdata_q <= ctl1_q;
			else if (paddr == adc_seq_pkg::OFS_SAMPLE0)
				prdata_q <= sample0_q;
			else if (paddr == adc_seq_pkg::OFS_SAMPLE1)
				prdata_q <= sample1_q;
			else if (paddr == adc_seq_pkg::OFS_HIGH)
				prdata_q <= {20'h0, high_q};
			else if (paddr == adc_seq_pkg::OFS_LOW)
				prdata_q <= {20'h0, low_q};
			else if (paddr == adc_seq_pkg::OFS_SEQ0)
				prdata_q <= seq0_q;
			else if (paddr == adc_seq_pkg::OFS_SEQ1)
				prdata_q <= seq1_q;
			else if (paddr == adc_seq_pkg::OFS_SEQ2)
				prdata_q <= seq2_q;
			else if (paddr == adc_seq_pkg::OFS_DATA)
				prdata_q <= {16'h0, data_q};
			else
				prdata_q <= '0; // unmapped reads as zero
		end
	end

	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	// control_reg_one; the software start bit clears when it is consumed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl1_q <= adc_seq_pkg::CTL1_RESET;
		else if (wr_en && paddr == adc_seq_pkg::OFS_CTL1)
			ctl1_q <= pwdata & adc_seq_pkg::CTL1_MASK | (pwdata & 32'h00400000);
		else if (!on || (trigger && state_q == adc_seq_pkg::SEQ_IDLE))
			ctl1_q[adc_seq_pkg::C1_SW_START] <= 1'b0;
	end

	// remaining plain configuration words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl0_q <= adc_seq_pkg::CTL0_RESET;
			sample0_q <= '0;
			sample1_q <= '0;
			high_q <= adc_seq_pkg::HIGH_RESET;
			low_q <= adc_seq_pkg::LOW_RESET;
			seq0_q <= '0;
			seq1_q <= '0;
			seq2_q <= '0;
		end
		else if (wr_en)
		begin
			if (paddr == adc_seq_pkg::OFS_CTL0)
				ctl0_q <= pwdata & adc_seq_pkg::CTL0_MASK;
			else if (paddr == adc_seq_pkg::OFS_SAMPLE0)
				sample0_q <= pwdata & adc_seq_pkg::SAMPLE0_MASK;
			else if (paddr == adc_seq_pkg::OFS_SAMPLE1)
				sample1_q <= pwdata & adc_seq_pkg::SAMPLE1_MASK;
			else if (paddr == adc_seq_pkg::OFS_HIGH)
				high_q <= pwdata[11:0];
			else if (paddr == adc_seq_pkg::OFS_LOW)
				low_q <= pwdata[11:0];
			else if (paddr == adc_seq_pkg::OFS_SEQ0)
				seq0_q <= pwdata & adc_seq_pkg::SEQ0_MASK;
			else if (paddr == adc_seq_pkg::OFS_SEQ1)
				seq1_q <= pwdata & adc_seq_pkg::SEQ_MASK;
			else if (paddr == adc_seq_pkg::OFS_SEQ2)
				seq2_q <= pwdata & adc_seq_pkg::SEQ_MASK;
		end
	end

	assign on = ctl1_q[adc_seq_pkg::C1_ON];
	assign scan = ctl0_q[adc_seq_pkg::C0_SCAN];
	assign disc = ctl0_q[adc_seq_pkg::C0_DISC];
	assign cont = ctl1_q[adc_seq_pkg::C1_CONT];

	////////////////////////////////////////////////////////////////////////
	// trigger pins: two flops, then an edge detector on the second stage

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_s1_all_q <= '0;
			trig_s2_q <= '0;
			trig_s3_q <= '0;
		end
		else
		begin
			trig_s1_all_q <= hw_trigger;
			trig_s2_q <= trig_s1_all_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	assign trig_edge = trig_s2_q & ~trig_s3_q;

	// software bit starts whenever the converter is on; a pin only when also enabled and selected
	always_comb
	begin
		trigger = ctl1_q[adc_seq_pkg::C1_SW_START];
		if (ctl1_q[adc_seq_pkg::C1_TRIG_EN]
			&& ctl1_q[adc_seq_pkg::C1_TRIG_SEL +: 3] != adc_seq_pkg::TRIG_SOFTWARE)
			trigger = trigger | trig_edge[ctl1_q[adc_seq_pkg::C1_TRIG_SEL +: 3]];
		trigger = trigger && on;
	end

	////////////////////////////////////////////////////////////////////////
	// sequence stepping

	assign last_pos = seq0_q[adc_seq_pkg::SEQ_LEN_POS +: 4];
	// single and continuous modes only ever use the first slot
	assign last_slot = (!scan && !disc) || pos_q == last_pos;

	// decide whether and where the next channel starts
	always_comb
	begin
		launch = 1'b0;
		launch_pos = pos_q;
		pass_done = 1'b0;
		if (state_q == adc_seq_pkg::SEQ_IDLE)
		begin
			launch = trigger;
			launch_pos = disc ? pos_q : 4'h0;
		end
		else if (conv_done)
		begin
			pass_done = last_slot;
			if (disc)
			begin
				// a burst stops after the count field plus one channels or at the sequence end
				launch_pos = last_slot ? 4'h0 : pos_q + 4'h1;
				launch = !last_slot && group_q != ctl0_q[adc_seq_pkg::C0_DISC_CNT +: 3];
			end
			else if (scan)
			begin
				launch_pos = last_slot ? 4'h0 : pos_q + 4'h1;
				launch = !last_slot || cont;
			end
			else
			begin
				launch_pos = 4'h0;
				launch = cont;
			end
		end
	end

	assign launch_chan = slot_chan(launch_pos, seq0_q, seq1_q, seq2_q);
	assign launch_code = sample_code(launch_chan, sample0_q, sample1_q);

	// sequencer state, slot pointer and burst count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= adc_seq_pkg::SEQ_IDLE;
			pos_q <= '0;
			group_q <= '0;
			chan_q <= '0;
		end
		else if (!on)
		begin
			// converter off holds everything at its idle values
			state_q <= adc_seq_pkg::SEQ_IDLE;
			pos_q <= '0;
			group_q <= '0;
			chan_q <= '0;
		end
		else
		begin
			case (state_q)
				adc_seq_pkg::SEQ_IDLE:
				begin
					if (launch)
					begin
						state_q <= adc_seq_pkg::SEQ_CONVERT;
						pos_q <= launch_pos;
						group_q <= '0;
						chan_q <= launch_chan;
					end
				end
				adc_seq_pkg::SEQ_CONVERT:
				begin
					if (conv_done)
					begin
						pos_q <= launch_pos;
						group_q <= group_q + 3'h1;
						chan_q <= launch_chan;
						if (!launch)
							state_q <= adc_seq_pkg::SEQ_IDLE;
					end
				end
				default:
					state_q <= adc_seq_pkg::SEQ_IDLE;
			endcase
		end
	end

	// one timer serves every channel; back-to-back launches wait one cycle
	adc_conv_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.enable(on),
		.start(launch && !timer_busy),
		.sample_code(launch_code),
		.sampling(sample_active),
		.busy(timer_busy),
		.done(conv_done)
	);

	assign sample_channel = chan_q;
	assign convert_active = timer_busy && !sample_active;

	////////////////////////////////////////////////////////////////////////
	// result, watchdog and flags

	// six-bit results arrive in the low bits of the core result
	assign raw = ctl1_q[adc_seq_pkg::C1_SIX_BIT] ? {6'h00, conv_result[5:0]} : conv_result;

	// data register: every finished channel overwrites it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_q <= '0;
		else if (conv_done && state_q == adc_seq_pkg::SEQ_CONVERT)
			data_q <= adc_seq_pkg::align_result(conv_result, ctl1_q[adc_seq_pkg::C1_LEFT],
				ctl1_q[adc_seq_pkg::C1_SIX_BIT]);
	end

	// monitored set is one chosen channel or all of them
	assign watched = ctl0_q[adc_seq_pkg::C0_WDOG_EN] && (!ctl0_q[adc_seq_pkg::C0_WD_SINGLE]
		|| chan_q == ctl0_q[adc_seq_pkg::C0_WDCH +: 5]);
	// thresholds meet the raw value so alignment never matters
	assign outside = raw > high_q || raw < low_q;

	// sticky flags; a hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_flag_q <= 1'b0;
			wd_flag_q <= 1'b0;
		end
		else
		begin
			if (conv_done && pass_done)
				done_flag_q <= 1'b1;
			else if (wr_en && paddr == adc_seq_pkg::OFS_STATUS && !pwdata[adc_seq_pkg::ST_DONE])
				done_flag_q <= 1'b0;
			if (conv_done && watched && outside)
				wd_flag_q <= 1'b1;
			else if (wr_en && paddr == adc_seq_pkg::OFS_STATUS && !pwdata[adc_seq_pkg::ST_WDOG])
				wd_flag_q <= 1'b0;
		end
	end

	// dma request pulse after every channel
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dma_q <= 1'b0;
		else
			dma_q <= conv_done && ctl1_q[adc_seq_pkg::C1_DMA];
	end

	assign dma_request = dma_q;

	// one interrupt line gated by the two enables
	assign irq = (done_flag_q && ctl0_q[adc_seq_pkg::C0_DONE_IE])
		|| (wd_flag_q && ctl0_q[adc_seq_pkg::C0_WDOG_IE]);

endmodule

`default_nettype wire

// ==== adc_seq_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

// pin-level watcher; mirrors the few enables it needs from apb writes
module adc_seq_chk (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core side and requests
	input wire logic [4:0] sample_channel,
	input wire logic sample_active,
	input wire logic convert_active,
	input wire logic dma_request,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr; // a write lands at this edge
	logic done_ie_q, wd_ie_q, dma_q, on_q; // shadowed enables
	logic [4:0] tail_q; // cycles seen in the running tail

	assign wr = psel && penable && pwrite && pready;

	////////////////////////////////////////////////////////////////////////////////
	// shadows update at the same edge as the device registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_ie_q <= 1'b0;
			wd_ie_q <= 1'b0;
			dma_q <= 1'b0;
			on_q <= 1'b0;
		end
		else if (wr && paddr == adc_seq_pkg::OFS_CTL0)
		begin
			done_ie_q <= pwdata[adc_seq_pkg::C0_DONE_IE];
			wd_ie_q <= pwdata[adc_seq_pkg::C0_WDOG_IE];
		end
		else if (wr && paddr == adc_seq_pkg::OFS_CTL1)
		begin
			dma_q <= pwdata[adc_seq_pkg::C1_DMA];
			on_q <= pwdata[adc_seq_pkg::C1_ON];
		end
	end

	// tail length counter, cleared whenever the tail is not running
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tail_q <= 5'h00;
		else
			tail_q <= convert_active ? tail_q + 5'h01 : 5'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	chk_ready_now: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	chk_unmapped_err: assert property (psel && penable && !pwrite && paddr > adc_seq_pkg::OFS_DATA
		|-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	chk_mapped_ok: assert property (psel && penable && paddr <= adc_seq_pkg::OFS_DATA
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
	chk_irq_gate: assert property (irq |-> done_ie_q || wd_ie_q)
		else $error("irq without an enable");
	chk_dma_gate: assert property (dma_request |-> dma_q)
		else $error("dma request while disabled");
	chk_dma_pulse: assert property (dma_request |-> $past(convert_active, 2) ##1 !dma_request)
		else $error("dma request not a single pulse after a tail");
	chk_off_idle: assert property ((!on_q) [*2] |-> !sample_active && !convert_active)
		else $error("activity while converter off");
	chk_one_phase: assert property (!(sample_active && convert_active))
		else $error("sample and tail overlap");
	chk_tail_len: assert property ($fell(convert_active) && on_q |-> tail_q == 5'd13)
		else $error("tail not 13 cycles");
	chk_sample_min: assert property ($rose(sample_active) |=> sample_active)
		else $error("sample window shorter than two cycles");
	chk_sample_tail: assert property ($fell(sample_active) && on_q |-> convert_active)
		else $error("tail does not follow sample window");
	chk_chan_hold: assert property (sample_active && $past(sample_active)
		|-> $stable(sample_channel)) else $error("channel moved in sample window");
endmodule

bind adc_routine_sequencer adc_seq_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .sample_channel, .sample_active,
	.convert_active, .dma_request, .irq);

`default_nettype wire

// ==== analog_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// analog core stand-in: result is valid only in the tail and one cycle after
module analog_core_model (
	// clock
	input wire logic pclk,
	// from the sequencer
	input wire logic [4:0] sample_channel,
	input wire logic convert_active,
	// result
	output logic [11:0] conv_result
);
	logic [11:0] junk_q = 12'h5a5; // toggles so a stale read never looks right
	logic late_q = 1'b0; // result still held one cycle past the tail

	// outside the valid window the bus flips every cycle
	always @(posedge pclk)
	begin
		junk_q <= ~junk_q;
		late_q <= convert_active;
	end

	assign conv_result = (convert_active || late_q) ? {sample_channel[3:0], 8'ha5} : junk_q;
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none

// self-checking bench: table of single conversions, then modes and reset
module tb;
	// one single conversion: channel, controls, and what it should give
	typedef struct {logic [4:0] ch; logic [31:0] c0; logic [31:0] c1; logic [15:0] data;
		logic [2:0] st; logic irq; int samp;} row_t;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_request;
	logic sample_active, convert_active, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [6:0] hw_trigger;
	logic [4:0] sample_channel;
	logic [11:0] conv_result;
	int failures = 0;
	int n_compared = 0;
	int dma_n = 0;
	int samp_n = 0;
	int b0;
	// results are {ch[3:0], a5}; thresholds 0x100..0x7ff; ch9 samples with code 2
	row_t rows [5] = '{
		'{5'd3, 32'h800000, 32'h0, 16'h03a5, 3'h1, 1'b0, 2},
		'{5'd9, 32'h800040, 32'h800, 16'h9a50, 3'h3, 1'b1, 8},
		'{5'd0, 32'h800205, 32'h2000000, 16'h0025, 3'h1, 1'b0, 2},
		'{5'd0, 32'h800220, 32'h2000800, 16'h0094, 3'h3, 1'b1, 2},
		'{5'd9, 32'h20, 32'h0, 16'h09a5, 3'h1, 1'b1, 8}};

	adc_routine_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_trigger(hw_trigger), .sample_channel(sample_channel),
		.sample_active(sample_active), .convert_active(convert_active),
		.conv_result(conv_result), .dma_request(dma_request), .irq(irq));
	analog_core_model core (.pclk(pclk), .sample_channel(sample_channel),
		.convert_active(convert_active), .conv_result(conv_result));

	always #5 pclk = ~pclk;

	// pulse and sample-cycle counters, updated with nonblocking writes on the rising edge
	always @(posedge pclk)
	begin
		if (dma_request === 1'b1)
			dma_n <= dma_n + 1;
		if (sample_active === 1'b1)
			samp_n <= samp_n + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; waits for pready rather than assuming zero wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// poll the done flag with a bound
	task automatic wait_done;
		int n;
		n = 0;
		rd(adc_seq_pkg::OFS_STATUS);
		while (r[0] !== 1'b1 && n < 300)
		begin
			n++;
			rd(adc_seq_pkg::OFS_STATUS);
		end
		repeat (3) @(negedge pclk);
		check("done flag", 32'h1, {31'h0, r[0]});
	endtask

	// pins pass a synchroniser, so hold the level for a few cycles
	task automatic pulse_pin(input int p);
		@(posedge pclk);
		hw_trigger[p] <= 1'b1;
		repeat (4) @(posedge pclk);
		hw_trigger[p] <= 1'b0;
		repeat (100) @(negedge pclk);
	endtask

	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, hw_trigger} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wr(adc_seq_pkg::OFS_HIGH, 32'h7ff);
		wr(adc_seq_pkg::OFS_LOW, 32'h100);
		wr(adc_seq_pkg::OFS_SAMPLE0, 32'h10000000);
		foreach (rows[i])
		begin
			wr(adc_seq_pkg::OFS_CTL0, rows[i].c0);
			wr(adc_seq_pkg::OFS_SEQ2, {27'h0, rows[i].ch});
			wr(adc_seq_pkg::OFS_CTL1, rows[i].c1 | 32'h1);
			b0 = samp_n;
			wr(adc_seq_pkg::OFS_CTL1, rows[i].c1 | 32'h400001);
			wait_done;
			check("sample cycles", rows[i].samp, samp_n - b0);
			check("irq", {31'h0, rows[i].irq}, {31'h0, irq});
			rd(adc_seq_pkg::OFS_DATA);
			check("data", {16'h0, rows[i].data}, r);
			rd(adc_seq_pkg::OFS_STATUS);
			check("status", {29'h0, rows[i].st}, r);
			wr(adc_seq_pkg::OFS_STATUS, 32'h0);
			rd(adc_seq_pkg::OFS_STATUS);
			check("status cleared", 32'h0, r);
			check("irq cleared", 32'h0, {31'h0, irq});
		end
		rd(8'h2c);
		check("unmapped error", 32'h1, {31'h0, e});
		check("unmapped data", 32'h0, r);
		// scan of three slots ch3, ch5, ch9 on one start
		wr(adc_seq_pkg::OFS_CTL0, 32'h100);
		wr(adc_seq_pkg::OFS_SEQ0, 32'h200000);
		wr(adc_seq_pkg::OFS_SEQ2, 32'h24a3);
		wr(adc_seq_pkg::OFS_CTL1, 32'h101);
		b0 = dma_n;
		wr(adc_seq_pkg::OFS_CTL1, 32'h400101);
		wait_done;
		check("scan dma", 32'd3, dma_n - b0);
		rd(adc_seq_pkg::OFS_DATA);
		check("scan data", 32'h09a5, r);
		wr(adc_seq_pkg::OFS_STATUS, 32'h0);
		// discontinuous, two slots per pin trigger, four slots
		wr(adc_seq_pkg::OFS_CTL0, 32'h2800);
		wr(adc_seq_pkg::OFS_SEQ0, 32'h300000);
		wr(adc_seq_pkg::OFS_SEQ2, 32'h20c41);
		wr(adc_seq_pkg::OFS_CTL1, 32'h160101);
		b0 = dma_n;
		pulse_pin(3);
		check("part dma", 32'd2, dma_n - b0);
		rd(adc_seq_pkg::OFS_STATUS);
		check("part status", 32'h0, r);
		pulse_pin(3);
		check("pass dma", 32'd4, dma_n - b0);
		rd(adc_seq_pkg::OFS_STATUS);
		check("pass status", 32'h1, r);
		wr(adc_seq_pkg::OFS_STATUS, 32'h0);
		// continuous single, then continuous scan of ch1, ch2; then switch off
		for (int s = 0; s < 2; s++)
		begin
			wr(adc_seq_pkg::OFS_CTL0, s ? 32'h100 : 32'h0);
			wr(adc_seq_pkg::OFS_SEQ0, s ? 32'h100000 : 32'h0);
			wr(adc_seq_pkg::OFS_CTL1, 32'h103);
			b0 = dma_n;
			wr(adc_seq_pkg::OFS_CTL1, 32'h400103);
			repeat (150) @(negedge pclk);
			check("repeat dma", 32'h1, {31'h0, dma_n - b0 > 5});
			rd(adc_seq_pkg::OFS_DATA);
			if (s == 0)
				check("repeat data", 32'h01a5, r);
			wr(adc_seq_pkg::OFS_CTL1, 32'h0);
			repeat (3) @(negedge pclk);
			b0 = dma_n;
			check("off idle", 32'h0, {30'h0, sample_active, convert_active});
			repeat (40) @(negedge pclk);
			check("off dma", 32'h0, dma_n - b0);
			wr(adc_seq_pkg::OFS_STATUS, 32'h0);
		end
		// second reset mid-run restores the register reset values
		wr(adc_seq_pkg::OFS_HIGH, 32'h5);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(adc_seq_pkg::OFS_CTL0);
		check("ctl0 reset", 32'h0, r);
		rd(adc_seq_pkg::OFS_HIGH);
		check("high reset", 32'hfff, r);
		rd(adc_seq_pkg::OFS_LOW);
		check("low reset", 32'h0, r);
		give_verdict;
	end

	// watchdog: the sequence above needs well under this
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		give_verdict;
	end
endmodule

`default_nettype wire
